// ===== hdl/sfr_pkg.sv
package sfr_pkg;
    // Array and sector geometry
    localparam int SFR_ARRAY_AW   = 21;
    localparam int SFR_SECT_LSB   = 16;
    localparam int SFR_SECT_W     = SFR_ARRAY_AW - SFR_SECT_LSB;
    localparam int SFR_NUM_SECT   = 1 << SFR_SECT_W;
    localparam int SFR_OTP_AW     = 7;
    localparam logic [6:0] SFR_OTP_LAST = 7'h40;
    localparam int SFR_DW         = 8;
    localparam int SFR_FIFO_DEPTH = 8;

    // Frame counter end values, one less than each count of clock edges
    localparam logic [4:0] SFR_OP_LAST    = 5'h07;
    localparam logic [4:0] SFR_ADDR_LAST  = 5'h17;
    localparam logic [4:0] SFR_DUMMY_LAST = 5'h07;
    localparam logic [2:0] SFR_SINGLE_LAST = 3'h7;
    localparam logic [2:0] SFR_DUAL_LAST   = 3'h3;

    // Opcodes, plain defaults
    localparam logic [7:0] SFR_FAST_READ_CMD = 8'h0b;
    localparam logic [7:0] SFR_DUAL_READ_CMD = 8'h3b;
    localparam logic [7:0] SFR_LOCK_READ_CMD = 8'he8;
    localparam logic [7:0] SFR_OTP_READ_CMD  = 8'h4b;

    // Protection byte layout
    localparam int SFR_LOCK_WR_BIT   = 0;
    localparam int SFR_LOCK_DOWN_BIT = 1;
    localparam logic [1:0] SFR_LOCK_RST  = 2'h0;
    localparam logic [5:0] SFR_LOCK_RSVD = 6'h00;

    typedef enum logic [4:0] {
        SFR_ST_OPC    = 5'h01,
        SFR_ST_ADDR   = 5'h02,
        SFR_ST_DUMMY  = 5'h04,
        SFR_ST_DATA   = 5'h08,
        SFR_ST_IGNORE = 5'h10
    } sfr_state_t;

    typedef enum logic [3:0] {
        SFR_MODE_FAST = 4'h1,
        SFR_MODE_DUAL = 4'h2,
        SFR_MODE_LOCK = 4'h4,
        SFR_MODE_OTP  = 4'h8
    } sfr_mode_t;

    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic di;
    } sfr_pins_t;

    typedef struct packed {
        logic                    en;
        logic [SFR_ARRAY_AW-1:0] addr;
        logic [SFR_DW-1:0]       data;
    } sfr_arr_wr_t;

    typedef struct packed {
        logic                  en;
        logic [SFR_OTP_AW-1:0] addr;
        logic [SFR_DW-1:0]     data;
    } sfr_otp_wr_t;

    typedef struct packed {
        logic                  en;
        logic [SFR_SECT_W-1:0] sector;
        logic [1:0]            bits;
    } sfr_lock_wr_t;
endpackage : sfr_pkg

// ===== hdl/sfr_mem.sv
`timescale 1ns/100ps
module sfr_mem #(
    parameter int DW = 8,
    parameter int AW = 8
) (
    input  wire logic          mclk,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    input  wire logic          rd_en,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge mclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule : sfr_mem

// ===== hdl/sfr_fifo.sv
`timescale 1ns/100ps
module sfr_fifo #(
    parameter int DW    = 8,
    parameter int DEPTH = 8
) (
    input  wire logic          mclk,
    input  wire logic          nrst,
    input  wire logic          flush,
    input  wire logic          in_valid,
    output logic               in_ready,
    input  wire logic [DW-1:0] in_data,
    output logic               out_valid,
    input  wire logic          out_ready,
    output logic      [DW-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [DW-1:0] buf_r [0:DEPTH-1];
    logic [PW-1:0] wp_r;
    logic [PW-1:0] rp_r;
    logic [PW:0]   cnt_r;
    logic          push;
    logic          pop;

    assign in_ready  = (cnt_r != (PW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = buf_r[rp_r];

    always_ff @(posedge mclk) begin
        if (push) begin
            buf_r[wp_r] <= in_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst || flush) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == PW'(DEPTH-1)) ? '0 : wp_r + PW'(1);
            end
            if (pop) begin
                rp_r <= (rp_r == PW'(DEPTH-1)) ? '0 : rp_r + PW'(1);
            end
            cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule : sfr_fifo

// ===== hdl/sfr_read_top.sv
`timescale 1ns/100ps
module sfr_read_top
    import sfr_pkg::*;
#(
    parameter int FIFO_DEPTH = SFR_FIFO_DEPTH
) (
    input  wire logic         mclk,
    input  wire logic         nrst,
    input  wire logic         sclk,
    input  wire logic         cs_n,
    input  wire logic         serial_io_low_i,
    output logic              serial_io_low_o,
    output logic              serial_io_low_oe,
    output logic              serial_io_high_o,
    output logic              serial_io_high_oe,
    input  wire logic         cycle_run,
    output logic              cycle_busy_flag,
    input  wire sfr_arr_wr_t  arr_wr,
    output logic              arr_wr_refused,
    input  wire sfr_otp_wr_t  otp_wr,
    input  wire sfr_lock_wr_t lock_wr
);
    sfr_pins_t             pin_s1_r;
    sfr_pins_t             pin_s2_r;
    logic                  sclk_d_r;
    logic                  rise;
    logic                  fall;
    logic                  desel;
    sfr_state_t            st_r;
    sfr_mode_t             mode_r;
    logic [4:0]            cnt_r;
    logic [7:0]            op_sh_r;
    logic [22:0]           addr_sh_r;
    logic [7:0]            op_w;
    logic [23:0]           addr_w;
    logic                  op_done;
    logic                  addr_done_r;
    logic [23:0]           cap_addr_r;
    logic [SFR_SECT_W-1:0] lock_sec_r;
    logic [1:0]            lock_r [0:SFR_NUM_SECT-1];
    logic                  fetch_on_r;
    logic                  pend_r;
    logic [SFR_ARRAY_AW-1:0] fetch_addr_r;
    logic                  rd_issue;
    logic [SFR_DW-1:0]     arr_rd;
    logic [SFR_DW-1:0]     otp_rd;
    logic                  fifo_in_ready;
    logic                  fifo_out_valid;
    logic                  fifo_pop;
    logic [SFR_DW-1:0]     fifo_out;
    logic [SFR_DW-1:0]     lock_byte;
    logic [SFR_DW-1:0]     sh_r;
    logic [2:0]            left_r;
    logic [2:0]            idx_r;
    logic                  load;
    logic [SFR_DW-1:0]     load_byte;

    // Pin synchronisers and edge detect
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            pin_s1_r <= '{sclk: 1'b0, cs_n: 1'b1, di: 1'b0};
            pin_s2_r <= '{sclk: 1'b0, cs_n: 1'b1, di: 1'b0};
            sclk_d_r <= 1'b0;
        end else begin
            pin_s1_r <= '{sclk: sclk, cs_n: cs_n, di: serial_io_low_i};
            pin_s2_r <= pin_s1_r;
            sclk_d_r <= pin_s2_r.sclk;
        end
    end

    assign desel = pin_s2_r.cs_n;
    assign rise  = pin_s2_r.sclk && !sclk_d_r && !desel;
    assign fall  = !pin_s2_r.sclk && sclk_d_r && !desel;
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cycle_busy_flag <= 1'b0;
        end else begin
            cycle_busy_flag <= cycle_run;
        end
    end

    // Instruction framing
    assign op_w    = {op_sh_r[6:0], pin_s2_r.di};
    assign addr_w  = {addr_sh_r, pin_s2_r.di};
    assign op_done = rise && (st_r == SFR_ST_OPC) && (cnt_r == SFR_OP_LAST);
    always_ff @(posedge mclk) begin
        if (!nrst || desel) begin
            st_r        <= SFR_ST_OPC;
            mode_r      <= SFR_MODE_FAST;
            cnt_r       <= '0;
            op_sh_r     <= '0;
            addr_sh_r   <= '0;
            addr_done_r <= 1'b0;
            cap_addr_r  <= '0;
        end else begin
            addr_done_r <= 1'b0;
            if (rise) begin
                cnt_r <= cnt_r + 5'h01;
                case (st_r)
                    SFR_ST_OPC: begin
                        op_sh_r <= op_w;
                        if (cnt_r == SFR_OP_LAST) begin
                            cnt_r <= '0;
                            st_r  <= SFR_ST_ADDR;
                            case (op_w)
                                SFR_FAST_READ_CMD: mode_r <= SFR_MODE_FAST;
                                SFR_DUAL_READ_CMD: mode_r <= SFR_MODE_DUAL;
                                SFR_LOCK_READ_CMD: mode_r <= SFR_MODE_LOCK;
                                SFR_OTP_READ_CMD:  mode_r <= SFR_MODE_OTP;
                                default:           st_r   <= SFR_ST_IGNORE;
                            endcase
                            if (cycle_busy_flag) begin
                                st_r <= SFR_ST_IGNORE;
                            end
                        end
                    end
                    SFR_ST_ADDR: begin
                        addr_sh_r <= addr_w[22:0];
                        if (cnt_r == SFR_ADDR_LAST) begin
                            cnt_r       <= '0;
                            cap_addr_r  <= addr_w;
                            addr_done_r <= 1'b1;
                            st_r <= (mode_r == SFR_MODE_LOCK) ? SFR_ST_DATA : SFR_ST_DUMMY;
                        end
                    end
                    SFR_ST_DUMMY: begin
                        if (cnt_r == SFR_DUMMY_LAST) begin
                            cnt_r <= '0;
                            st_r  <= SFR_ST_DATA;
                        end
                    end
                    SFR_ST_DATA, SFR_ST_IGNORE: begin
                        cnt_r <= '0;
                    end
                    default: begin
                        st_r <= SFR_ST_IGNORE;
                    end
                endcase
            end
        end
    end

    // Sector protection bytes
    generate
        for (genvar g = 0; g < SFR_NUM_SECT; g++) begin : g_lock
            always_ff @(posedge mclk) begin
                if (!nrst) begin
                    lock_r[g] <= SFR_LOCK_RST;
                end else if (lock_wr.en && (lock_wr.sector == SFR_SECT_W'(g))
                             && !lock_r[g][SFR_LOCK_DOWN_BIT]) begin
                    lock_r[g] <= lock_wr.bits;
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            lock_sec_r <= '0;
        end else if (addr_done_r) begin
            lock_sec_r <= cap_addr_r[SFR_ARRAY_AW-1:SFR_SECT_LSB];
        end
    end

    assign lock_byte = {SFR_LOCK_RSVD, lock_r[lock_sec_r]};
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            arr_wr_refused <= 1'b0;
        end else begin
            arr_wr_refused <= arr_wr.en &&
                lock_r[arr_wr.addr[SFR_ARRAY_AW-1:SFR_SECT_LSB]][SFR_LOCK_WR_BIT];
        end
    end

    // Prefetch into the FIFO
    assign rd_issue = fetch_on_r && !pend_r && fifo_in_ready;
    always_ff @(posedge mclk) begin
        if (!nrst || desel) begin
            fetch_on_r   <= 1'b0;
            pend_r       <= 1'b0;
            fetch_addr_r <= '0;
        end else if (addr_done_r && mode_r != SFR_MODE_LOCK) begin
            fetch_on_r <= 1'b1;
            if (mode_r == SFR_MODE_OTP) begin
                fetch_addr_r <= (cap_addr_r[6:0] > SFR_OTP_LAST) ?
                                SFR_ARRAY_AW'(SFR_OTP_LAST) : SFR_ARRAY_AW'(cap_addr_r[6:0]);
            end else begin
                fetch_addr_r <= cap_addr_r[SFR_ARRAY_AW-1:0];
            end
        end else begin
            if (rd_issue) begin
                pend_r <= 1'b1;
            end
            if (pend_r) begin
                pend_r <= 1'b0;
                if (mode_r != SFR_MODE_OTP) begin
                    fetch_addr_r <= fetch_addr_r + SFR_ARRAY_AW'(1);
                end else if (fetch_addr_r[6:0] != SFR_OTP_LAST) begin
                    fetch_addr_r <= fetch_addr_r + SFR_ARRAY_AW'(1);
                end
            end
        end
    end

    sfr_mem #(.DW(SFR_DW), .AW(SFR_ARRAY_AW)) u_array (
        .mclk    (mclk),
        .wr_en   (arr_wr.en && !lock_r[arr_wr.addr[SFR_ARRAY_AW-1:SFR_SECT_LSB]][SFR_LOCK_WR_BIT]),
        .wr_addr (arr_wr.addr),
        .wr_data (arr_wr.data),
        .rd_en   (rd_issue),
        .rd_addr (fetch_addr_r),
        .rd_data (arr_rd)
    );

    sfr_mem #(.DW(SFR_DW), .AW(SFR_OTP_AW)) u_otp (
        .mclk    (mclk),
        .wr_en   (otp_wr.en),
        .wr_addr (otp_wr.addr),
        .wr_data (otp_wr.data),
        .rd_en   (rd_issue),
        .rd_addr (fetch_addr_r[SFR_OTP_AW-1:0]),
        .rd_data (otp_rd)
    );

    sfr_fifo #(.DW(SFR_DW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .mclk      (mclk),
        .nrst      (nrst),
        .flush     (desel),
        .in_valid  (pend_r),
        .in_ready  (fifo_in_ready),
        .in_data   ((mode_r == SFR_MODE_OTP) ? otp_rd : arr_rd),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out)
    );

    // Output shifter
    assign load      = fall && (st_r == SFR_ST_DATA) && (left_r == '0);
    assign fifo_pop  = load && (mode_r != SFR_MODE_LOCK) && fifo_out_valid;
    assign load_byte = (mode_r == SFR_MODE_LOCK) ? lock_byte : fifo_out;
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            serial_io_high_o <= 1'b0;
            serial_io_low_o  <= 1'b0;
            sh_r             <= '0;
            left_r           <= '0;
            idx_r            <= '0;
        end else if (desel) begin
            left_r <= '0;
        end else if (fall && st_r == SFR_ST_DATA) begin
            serial_io_high_o <= load ? load_byte[7] : sh_r[7];
            serial_io_low_o  <= load ? load_byte[6] : sh_r[6];
            if (mode_r == SFR_MODE_DUAL) begin
                sh_r   <= load ? {load_byte[5:0], 2'b00} : {sh_r[5:0], 2'b00};
                left_r <= load ? SFR_DUAL_LAST : left_r - 3'h1;
                idx_r  <= load ? 3'h7 : idx_r - 3'h2;
            end else begin
                sh_r   <= load ? {load_byte[6:0], 1'b0} : {sh_r[6:0], 1'b0};
                left_r <= load ? SFR_SINGLE_LAST : left_r - 3'h1;
                idx_r  <= load ? 3'h7 : idx_r - 3'h1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst || desel) begin
            serial_io_high_oe <= 1'b0;
            serial_io_low_oe  <= 1'b0;
        end else if (fall && st_r == SFR_ST_DATA) begin
            serial_io_high_oe <= 1'b1;
            serial_io_low_oe  <= (mode_r == SFR_MODE_DUAL);
        end
    end

    a_busy_reject: assert property (@(posedge mclk) disable iff (!nrst)
        (op_done && cycle_busy_flag) |=> (st_r == SFR_ST_IGNORE))
        else $error("read accepted while busy");
    a_busy_follow: assert property (@(posedge mclk) disable iff (!nrst)
        1'b1 |=> (cycle_busy_flag == $past(cycle_run)))
        else $error("busy flag does not follow cycle");
    a_deselect_release: assert property (@(posedge mclk) disable iff (!nrst)
        desel |=> (!serial_io_high_oe && !serial_io_low_oe && st_r == SFR_ST_OPC))
        else $error("still driving after deselect");
    a_lock_no_dummy: assert property (@(posedge mclk) disable iff (!nrst)
        (rise && st_r == SFR_ST_ADDR && cnt_r == SFR_ADDR_LAST && mode_r == SFR_MODE_LOCK)
        |=> (st_r == SFR_ST_DATA))
        else $error("lock read did not skip dummy");
    a_out_on_fall: assert property (@(posedge mclk) disable iff (!nrst)
        $changed(serial_io_high_o) |-> $past(fall))
        else $error("output changed off a falling edge");
    a_dual_only_low: assert property (@(posedge mclk) disable iff (!nrst)
        serial_io_low_oe |-> (mode_r == SFR_MODE_DUAL && serial_io_high_oe))
        else $error("low line driven outside dual read");
    a_lock_reserved: assert property (@(posedge mclk) disable iff (!nrst)
        (serial_io_high_oe && mode_r == SFR_MODE_LOCK && idx_r > 3'h1) |-> !serial_io_high_o)
        else $error("reserved protection bit reads one");
    a_lock_frozen: assert property (@(posedge mclk) disable iff (!nrst)
        (lock_wr.en && lock_r[lock_wr.sector][SFR_LOCK_DOWN_BIT])
        |=> (lock_r[$past(lock_wr.sector)] == $past(lock_r[lock_wr.sector])))
        else $error("locked-down protection bits changed");
    a_lock_update: assert property (@(posedge mclk) disable iff (!nrst)
        (lock_wr.en && !lock_r[lock_wr.sector][SFR_LOCK_DOWN_BIT])
        |=> (lock_r[$past(lock_wr.sector)] == $past(lock_wr.bits)))
        else $error("protection bits not updated");
    a_write_refused: assert property (@(posedge mclk) disable iff (!nrst)
        (arr_wr.en && lock_r[arr_wr.addr[SFR_ARRAY_AW-1:SFR_SECT_LSB]][SFR_LOCK_WR_BIT])
        |=> arr_wr_refused)
        else $error("write to protected sector not refused");
    a_addr_step: assert property (@(posedge mclk) disable iff (!nrst || desel)
        (pend_r && fetch_on_r && mode_r != SFR_MODE_OTP && !addr_done_r)
        |=> (fetch_addr_r == $past(fetch_addr_r) + SFR_ARRAY_AW'(1)))
        else $error("array address did not step");
    a_otp_saturate: assert property (@(posedge mclk) disable iff (!nrst)
        (fetch_on_r && mode_r == SFR_MODE_OTP) |-> (fetch_addr_r <= SFR_ARRAY_AW'(SFR_OTP_LAST)))
        else $error("OTP address beyond last byte");
endmodule : sfr_read_top

// ===== sim/sfr_host_model.sv
`timescale 1ns/100ps
module sfr_host_model (
    output logic     sclk,
    output logic     cs_n,
    output logic     mosi,
    input  wire logic io_high,
    input  wire logic io_low,
    input  wire logic oe_any
);
    logic [7:0] rx [8];
    logic       saw_oe;

    initial begin
        sclk   = 1'b0;
        cs_n   = 1'b1;
        mosi   = 1'b0;
        saw_oe = 1'b0;
    end

    // Clock stays low between frames
    task automatic send_bit(input logic b);
        sclk = 1'b0;
        mosi = b;
        #100 sclk = 1'b1;
        #100;
    endtask : send_bit

    task automatic xfer(input logic [7:0] op, input logic [23:0] addr, input int ndum,
                        input int nbytes, input logic dual);
        logic [31:0] hdr;
        int          bpb;
        int          k;
        hdr    = {op, addr};
        bpb    = dual ? 4 : 8;
        saw_oe = 1'b0;
        cs_n   = 1'b0;
        #100;
        for (int i = 31; i >= 0; i--) send_bit(hdr[i]);
        for (int i = 0; i < ndum; i++) send_bit(1'b0);
        for (int i = 0; i < nbytes * bpb; i++) begin
            // Released line toggles so stale values never match
            sclk = 1'b0;
            mosi = ~mosi;
            #100 sclk = 1'b1;
            #99;
            k      = i / bpb;
            saw_oe = saw_oe | oe_any;
            rx[k]  = dual ? {rx[k][5:0], io_high, io_low} : {rx[k][6:0], io_high};
            #1;
        end
        sclk = 1'b0;
        #100 cs_n = 1'b1;
        mosi = ~mosi;
        // Deselect gap so back-to-back frames are seen apart
        #200;
    endtask : xfer
endmodule : sfr_host_model

// ===== sim/serial_flash_read_commands_bench.sv
`timescale 1ns/100ps
module serial_flash_read_commands_bench;
    import sfr_pkg::*;

    logic         mclk;
    logic         nrst;
    logic         sclk;
    logic         cs_n;
    logic         host_do;
    logic         low_wire;
    logic         low_o;
    logic         low_oe;
    logic         high_wire;
    logic         high_o;
    logic         high_oe;
    logic         cycle_run;
    logic         busy;
    logic         refused;
    logic         r;
    sfr_arr_wr_t  arr_wr;
    sfr_otp_wr_t  otp_wr;
    sfr_lock_wr_t lock_wr;
    int           miscompares;
    int           tests_run;
    int           cycles;
    logic [7:0]   ops [4];

    // Shared low line
    assign low_wire = low_oe ? low_o : host_do;
    // Released high line shows the inverse of the held value
    assign high_wire = high_oe ? high_o : ~high_o;

    sfr_read_top #(.FIFO_DEPTH(SFR_FIFO_DEPTH)) uut (
        .mclk(mclk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n),
        .serial_io_low_i(low_wire), .serial_io_low_o(low_o), .serial_io_low_oe(low_oe),
        .serial_io_high_o(high_o), .serial_io_high_oe(high_oe), .cycle_run(cycle_run),
        .cycle_busy_flag(busy), .arr_wr(arr_wr), .arr_wr_refused(refused),
        .otp_wr(otp_wr), .lock_wr(lock_wr)
    );

    sfr_host_model host (
        .sclk(sclk), .cs_n(cs_n), .mosi(host_do), .io_high(high_wire), .io_low(low_wire),
        .oe_any(high_oe | low_oe)
    );

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            end_sim();
        end
    end

    task automatic end_sim;
        if (miscompares == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic arr_write(input logic [20:0] a, input logic [7:0] d, output logic rf);
        @(posedge mclk) #2 arr_wr = '{en: 1'b1, addr: a, data: d};
        @(posedge mclk) #2 arr_wr.en = 1'b0;
        rf = refused;
    endtask : arr_write

    task automatic otp_write(input logic [6:0] a, input logic [7:0] d);
        @(posedge mclk) #2 otp_wr = '{en: 1'b1, addr: a, data: d};
        @(posedge mclk) #2 otp_wr.en = 1'b0;
    endtask : otp_write

    task automatic lock_write(input logic [4:0] s, input logic [1:0] b);
        @(posedge mclk) #2 lock_wr = '{en: 1'b1, sector: s, bits: b};
        @(posedge mclk) #2 lock_wr.en = 1'b0;
    endtask : lock_write

    task automatic rd(input logic [7:0] op, input logic [23:0] a, input int nd, input int n,
                      input logic dual, input logic [63:0] exp);
        host.xfer(op, a, nd, n, dual);
        repeat (8) @(posedge mclk);
        #2;
        check("oe_after_cs", 8'h00, {6'h00, high_oe, low_oe});
        for (int i = 0; i < n; i++) check("rx_byte", exp[63-8*i -: 8], host.rx[i]);
    endtask : rd

    initial begin
        nrst        = 1'b0;
        cycle_run   = 1'b0;
        arr_wr      = '0;
        otp_wr      = '0;
        lock_wr     = '0;
        miscompares = 0;
        tests_run   = 0;
        cycles      = 0;
        ops         = '{SFR_FAST_READ_CMD, SFR_DUAL_READ_CMD, SFR_LOCK_READ_CMD, SFR_OTP_READ_CMD};
        repeat (5) @(posedge mclk);
        #2 nrst = 1'b1;
        repeat (4) @(posedge mclk);
        check("busy_rst", 8'h00, {7'h00, busy});
        arr_write(21'h1ffffe, 8'h3c, r);
        arr_write(21'h1fffff, 8'hc3, r);
        arr_write(21'h000000, 8'h96, r);
        rd(SFR_FAST_READ_CMD, 24'hdffffe, 8, 3, 1'b0, {24'h3cc396, 40'h0});
        rd(SFR_DUAL_READ_CMD, 24'h5ffffe, 8, 3, 1'b1, {24'h3cc396, 40'h0});
        lock_write(5'h01, 2'h1);
        rd(SFR_LOCK_READ_CMD, 24'h01abcd, 0, 2, 1'b0, {16'h0101, 48'h0});
        arr_write(21'h010000, 8'h11, r);
        check("refused_locked", 8'h01, {7'h00, r});
        lock_write(5'h01, 2'h2);
        lock_write(5'h01, 2'h1);
        rd(SFR_LOCK_READ_CMD, 24'h01ffff, 0, 1, 1'b0, {8'h02, 56'h0});
        arr_write(21'h010000, 8'h11, r);
        check("refused_open", 8'h00, {7'h00, r});
        otp_write(7'h3f, 8'ha5);
        otp_write(7'h40, 8'h5a);
        rd(SFR_OTP_READ_CMD, 24'hffffbf, 8, 3, 1'b0, {24'ha55a5a, 40'h0});
        @(posedge mclk) #2 cycle_run = 1'b1;
        repeat (2) @(posedge mclk);
        #2;
        check("busy_run", 8'h01, {7'h00, busy});
        foreach (ops[i]) begin
            host.xfer(ops[i], 24'h000000, 8, 1, 1'b0);
            check("busy_oe", 8'h00, {7'h00, host.saw_oe});
        end
        @(posedge mclk) #2 cycle_run = 1'b0;
        repeat (2) @(posedge mclk);
        #2;
        check("busy_done", 8'h00, {7'h00, busy});
        rd(SFR_FAST_READ_CMD, 24'h1fffff, 8, 2, 1'b0, {16'hc396, 48'h0});
        end_sim();
    end
endmodule : serial_flash_read_commands_bench
